/* verilog/dmsp_pkg.sv */
`default_nettype none
package dmsp_pkg;
	// clock and rate limits
	localparam int CLK_HZ   = 50_000_000;                // system clock, hz
	localparam int BAUD_MIN = 300;                       // slowest async rate, bps
	localparam int BAUD_MAX = 153_600;                   // fastest async rate, bps
	localparam int BAUD_DEF = 9_600;                     // rate after reset, bps
	localparam int DIV_W    = 18;                        // bit-period counter width
	localparam int DIV_DEF  = CLK_HZ / BAUD_DEF;         // reset bit period, cycles
	localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / BAUD_MAX); // shortest bit period
	localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN); // longest bit period
	// apb byte addresses
	localparam logic [7:0] ADDR_MODE_A  = 8'h00;         // port_mode_reg_a
	localparam logic [7:0] ADDR_MODE_B  = 8'h04;         // port_mode_reg_b
	localparam logic [7:0] ADDR_STATUS  = 8'h08;         // port_status_reg
	localparam logic [7:0] ADDR_RXB_W   = 8'h0C;         // rx_buffer_word
	localparam logic [7:0] ADDR_RXB_L   = 8'h10;         // rx_buffer_low_byte
	localparam logic [7:0] ADDR_TXS_W   = 8'h14;         // tx_shift_word
	localparam logic [7:0] ADDR_TXS_L   = 8'h18;         // tx_shift_low_byte
	localparam logic [7:0] ADDR_BAUD    = 8'h1C;         // bit period divisor
	// reset values
	localparam logic [7:0] MODE_A_RST   = 8'h81;
	localparam logic [7:0] MODE_B_RST   = 8'h00;
	// parity codes
	localparam logic [1:0] PAR_NONE = 2'h0;               // none, ninth bit allowed
	localparam logic [1:0] PAR_ZERO = 2'h1;               // parity bit always zero
	localparam logic [1:0] PAR_ODD  = 2'h2;
	localparam logic [1:0] PAR_EVEN = 2'h3;
	// character and stop lengths
	localparam logic [3:0] LEN_7    = 4'h7;
	localparam logic [3:0] LEN_8    = 4'h8;
	localparam logic [3:0] LEN_9    = 4'h9;
	localparam logic [3:0] STOP_ONE = 4'h1;
	localparam logic [3:0] STOP_TWO = 4'h2;
	// status bit positions
	localparam int ST_TX_ACT = 7;
	localparam int ST_RX_ACT = 6;
	localparam int ST_NINTH  = 3;
	localparam int ST_PERR   = 2;
	localparam int ST_FERR   = 1;
	localparam int ST_OVR    = 0;
	// mode register a layout
	typedef struct packed {
		logic       one7;          // reads as one
		logic       rx_enable_bit; // receiver on
		logic [1:0] parity;        // parity code
		logic       char_len_sel;  // 0: 7 bits, 1: 8 bits
		logic       stop_two;      // 0: one stop bit, 1: two
		logic       zero1;         // reads as zero
		logic       clk_src;       // sync mode: 1 internal, 0 external clock
	} dmsp_mode_a_type;
	// mode register b layout
	typedef struct packed {
		logic [3:0] zero;          // reads as zero
		logic       sync_mode;     // clocked mode
		logic       tx_two;        // two-frame transmit
		logic       rx_two;        // two-frame receive
		logic       ext_bit;       // ninth data bit
	} dmsp_mode_b_type;
	// transmitter and receiver states
	typedef enum logic [4:0] {
		TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PAR = 5'h08, TX_STOP = 5'h10
	} dmsp_tx_state_type;
	typedef enum logic [4:0] {
		RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PAR = 5'h08, RX_STOP = 5'h10
	} dmsp_rx_state_type;
	// ninth bit only with parity off
	function automatic logic ext_on(input dmsp_mode_a_type a, input dmsp_mode_b_type b);
		return b.ext_bit & (a.parity == PAR_NONE);
	endfunction
	// data bits per character
	function automatic logic [3:0] char_len(input dmsp_mode_a_type a, input dmsp_mode_b_type b);
		if (ext_on(a, b))
			return LEN_9;
		return a.char_len_sel ? LEN_8 : LEN_7;
	endfunction
	// parity bit from running xor of the data
	function automatic logic par_bit(input logic [1:0] mode, input logic acc);
		case (mode)
			PAR_ODD:  return ~acc;
			PAR_EVEN: return acc;
			default:  return 1'b0;
		endcase
	endfunction
endpackage
`default_nettype wire

/* verilog/dmsp_top.sv */
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module dmsp_top import dmsp_pkg::*; #(
	parameter int DIV_DEFAULT = DIV_DEF             // reset bit period, cycles
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rstn_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	input  wire logic        serial_rx_pin_in,
	output logic             serial_tx_pin_out,
	input  wire logic        serial_clock_pin_in,
	output logic             serial_clock_pin_out,
	output logic             serial_clock_pin_oe_out,
	output logic             rx_done_irq_out,
	output logic             tx_done_irq_out
);
	// reset release and pin synchronisers
	logic rst_meta_reg, rstn;                 // released reset copy
	logic rx_meta_reg, rx_s1_reg, rx_s2_reg;  // rx pin, two flops plus edge stage
	logic ck_meta_reg, ck_s1_reg, ck_s2_reg;  // clock pin, same
	// configuration
	dmsp_mode_a_type   mode_a_reg;            // port_mode_reg_a
	dmsp_mode_b_type   mode_b_reg;            // port_mode_reg_b
	logic [DIV_W-1:0]  baud_div_reg;          // bit period in cycles
	// apb slave
	logic [31:0] prdata_reg;                  // read data, loaded in setup
	logic        pready_reg, pslverr_reg;     // answer flags
	// internal clock generator
	logic [DIV_W-1:0] gen_cnt_reg;            // half period counter
	logic             sclk_int_reg;           // internal shift clock
	logic             sclk_pin_reg, sclk_oe_reg;
	// transmitter
	dmsp_tx_state_type tx_state_reg;
	logic [8:0]        tx_sh_reg;             // current character
	logic [7:0]        tx_hi_reg;             // second frame byte
	logic [3:0]        tx_cnt_reg;            // bits sent in phase
	logic              tx_acc_reg;            // running parity
	logic              tx_second_reg;         // second frame pending
	logic              tx_pend_reg;           // waiting for first step
	logic              tx_pin_reg, tx_irq_reg;
	// receiver
	dmsp_rx_state_type rx_state_reg;
	logic [8:0]        rx_sh_reg;             // incoming bits
	logic [3:0]        rx_cnt_reg;            // data bits taken
	logic [DIV_W-1:0]  rx_tmr_reg;            // async sample timer
	logic              rx_acc_reg;            // running parity
	logic [7:0]        rx_first_reg;          // first of two frames
	logic              rx_got1_reg;           // first frame held
	logic              pe_pend_reg, fe_pend_reg;
	logic [15:0]       rxb_reg;               // rx_buffer_word
	logic              rx_unread_reg, rx_irq_reg;
	logic              pe_flag_reg, fe_flag_reg, ovr_flag_reg;

	// apb decode
	wire setup    = psel_in & ~penable_in;
	wire wr_acc   = psel_in & penable_in & pready_reg & pwrite_in;
	wire rd_setup = setup & ~pwrite_in;
	wire hit_ma   = paddr_in == ADDR_MODE_A;
	wire hit_mb   = paddr_in == ADDR_MODE_B;
	wire hit_st   = paddr_in == ADDR_STATUS;
	wire hit_rw   = paddr_in == ADDR_RXB_W;
	wire hit_rl   = paddr_in == ADDR_RXB_L;
	wire hit_tw   = paddr_in == ADDR_TXS_W;
	wire hit_tl   = paddr_in == ADDR_TXS_L;
	wire hit_bd   = paddr_in == ADDR_BAUD;
	wire mapped   = hit_ma | hit_mb | hit_st | hit_rw | hit_rl | hit_tw | hit_tl | hit_bd;
	// mode decode
	wire        ext       = ext_on(mode_a_reg, mode_b_reg);
	wire [3:0]  len       = char_len(mode_a_reg, mode_b_reg);
	wire        par_on    = mode_a_reg.parity != PAR_NONE;
	wire [3:0]  stop_len  = mode_a_reg.stop_two ? STOP_TWO : STOP_ONE;
	wire        tx_two_on = mode_b_reg.tx_two & ~ext;
	wire        rx_two_on = mode_b_reg.rx_two & ~ext;
	wire        sync_on   = mode_b_reg.sync_mode;
	wire        ext_clk   = sync_on & ~mode_a_reg.clk_src;
	wire        rx_en     = mode_a_reg.rx_enable_bit;
	// status word
	wire [7:0] status = {tx_state_reg != TX_IDLE | tx_pend_reg,
		rx_state_reg != RX_IDLE, 2'h0, rxb_reg[8] & ext,
		pe_flag_reg, fe_flag_reg, ovr_flag_reg};
	// read mux
	wire [31:0] rd_word =
		hit_ma ? {24'h00_0000, mode_a_reg} :
		hit_mb ? {24'h00_0000, mode_b_reg} :
		hit_st ? {24'h00_0000, status} :
		hit_rw ? {16'h0000, rxb_reg} :
		hit_rl ? {24'h00_0000, rxb_reg[7:0]} :
		hit_bd ? {14'h0000, baud_div_reg} : 32'h0000_0000;
	wire rx_read  = rd_setup & (hit_rw | hit_rl);
	wire st_read  = rd_setup & hit_st;
	// shift clock events
	wire [DIV_W-1:0] half = {1'b0, baud_div_reg[DIV_W-1:1]};
	wire gen_tog  = gen_cnt_reg >= half - DIV_W'(1);
	wire int_rise = gen_tog & ~sclk_int_reg;
	wire int_fall = gen_tog & sclk_int_reg;
	wire ext_rise = ck_s1_reg & ~ck_s2_reg;
	wire ext_fall = ~ck_s1_reg & ck_s2_reg;
	wire sel_rise = ext_clk ? ext_rise : int_rise;
	wire sel_fall = ext_clk ? ext_fall : int_fall;
	wire tx_step  = sync_on ? sel_fall : int_rise;
	wire rx_fall  = ~rx_s1_reg & rx_s2_reg;
	wire rx_tick  = sync_on ? sel_rise : (rx_tmr_reg == '0) & (rx_state_reg != RX_IDLE);
	// transmit start and receive completion
	wire tx_load  = wr_acc & (hit_tw | hit_tl) & (tx_state_reg == TX_IDLE) & ~tx_pend_reg;
	wire rx_done  = (rx_state_reg == RX_STOP) & rx_tick;
	wire [8:0] rx_char = rx_sh_reg >> (LEN_9 - len);
	wire rx_first = rx_done & rx_two_on & ~rx_got1_reg;
	wire buf_load = rx_done & rx_en & ~rx_first;
	wire perr_now = (rx_state_reg == RX_PAR) & rx_tick & (rx_s1_reg != par_bit(mode_a_reg.parity, rx_acc_reg));

	// reset release
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_reg <= 1'b0;
			rstn         <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rstn         <= rst_meta_reg;
		end
	end

	// pin synchronisers, third stage only for edges
	always_ff @(posedge clk_sys_in or negedge rstn) begin
		if (!rstn) begin
			{rx_meta_reg, rx_s1_reg, rx_s2_reg} <= 3'h7;
			{ck_meta_reg, ck_s1_reg, ck_s2_reg} <= 3'h7;
		end else begin
			{rx_meta_reg, rx_s1_reg, rx_s2_reg} <= {serial_rx_pin_in, rx_meta_reg, rx_s1_reg};
			{ck_meta_reg, ck_s1_reg, ck_s2_reg} <= {serial_clock_pin_in, ck_meta_reg, ck_s1_reg};
		end
	end

	// apb answer: zero wait, data captured in setup
	always_ff @(posedge clk_sys_in or negedge rstn) begin
		if (!rstn) begin
			prdata_reg  <= 32'h0000_0000;
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup & ~mapped;
			if (setup)
				prdata_reg <= pwrite_in ? 32'h0000_0000 : rd_word;
		end
	end

	// configuration writes; mode a assumed written only while idle
	always_ff @(posedge clk_sys_in or negedge rstn) begin
		if (!rstn) begin
			mode_a_reg   <= dmsp_mode_a_type'(MODE_A_RST);
			mode_b_reg   <= dmsp_mode_b_type'(MODE_B_RST);
			baud_div_reg <= DIV_W'(DIV_DEFAULT);
		end else if (wr_acc) begin
			if (hit_ma)
				mode_a_reg <= dmsp_mode_a_type'({1'b1, pwdata_in[6:2], 1'b0, pwdata_in[0]});
			if (hit_mb)
				mode_b_reg <= dmsp_mode_b_type'({4'h0, pwdata_in[3:0]});
			if (hit_bd)
				baud_div_reg <= (pwdata_in[DIV_W-1:0] < DIV_MIN) ? DIV_MIN : pwdata_in[DIV_W-1:0];
		end
	end

	// internal baud generator and clock pin drive
	always_ff @(posedge clk_sys_in or negedge rstn) begin
		if (!rstn) begin
			gen_cnt_reg  <= '0;
			sclk_int_reg <= 1'b1;
			sclk_pin_reg <= 1'b1;
			sclk_oe_reg  <= 1'b0;
		end else begin
			gen_cnt_reg  <= gen_tog ? '0 : gen_cnt_reg + DIV_W'(1);
			if (gen_tog)
				sclk_int_reg <= ~sclk_int_reg;
			sclk_pin_reg <= sync_on & mode_a_reg.clk_src ? sclk_int_reg : 1'b1;
			sclk_oe_reg  <= sync_on & mode_a_reg.clk_src;
		end
	end

	// transmitter
	always_ff @(posedge clk_sys_in or negedge rstn) begin
		if (!rstn) begin
			tx_state_reg  <= TX_IDLE;
			tx_sh_reg     <= '0;
			tx_hi_reg     <= 8'h00;
			tx_cnt_reg    <= 4'h0;
			tx_acc_reg    <= 1'b0;
			tx_second_reg <= 1'b0;
			tx_pend_reg   <= 1'b0;
			tx_pin_reg    <= 1'b1;
			tx_irq_reg    <= 1'b0;
		end else begin
			tx_irq_reg <= 1'b0;
			case (tx_state_reg)
				TX_IDLE: begin
					if (tx_load) begin
						tx_pend_reg   <= 1'b1;
						tx_sh_reg     <= (ext & hit_tw) ? pwdata_in[8:0] : {1'b0, pwdata_in[7:0]};
						tx_hi_reg     <= hit_tw ? pwdata_in[15:8] : 8'h00;
						tx_second_reg <= tx_two_on;
					end else if (tx_pend_reg & tx_step) begin
						tx_pend_reg  <= 1'b0;
						tx_state_reg <= TX_START;
						tx_pin_reg   <= 1'b0;
					end
				end
				TX_START: begin
					if (tx_step) begin
						tx_state_reg <= TX_DATA;
						tx_pin_reg   <= tx_sh_reg[0];
						tx_acc_reg   <= tx_sh_reg[0];
						tx_sh_reg    <= {1'b0, tx_sh_reg[8:1]};
						tx_cnt_reg   <= 4'h1;
					end
				end
				TX_DATA: begin
					if (tx_step & (tx_cnt_reg == len)) begin
						tx_state_reg <= par_on ? TX_PAR : TX_STOP;
						tx_pin_reg   <= par_on ? par_bit(mode_a_reg.parity, tx_acc_reg) : 1'b1;
						tx_cnt_reg   <= 4'h1;
					end else if (tx_step) begin
						tx_pin_reg   <= tx_sh_reg[0];
						tx_acc_reg   <= tx_acc_reg ^ tx_sh_reg[0];
						tx_sh_reg    <= {1'b0, tx_sh_reg[8:1]};
						tx_cnt_reg   <= tx_cnt_reg + 4'h1;
					end
				end
				TX_PAR: begin
					if (tx_step) begin
						tx_state_reg <= TX_STOP;
						tx_pin_reg   <= 1'b1;
					end
				end
				TX_STOP: begin
					if (tx_step & (tx_cnt_reg == stop_len)) begin
						if (tx_second_reg) begin
							tx_second_reg <= 1'b0;
							tx_sh_reg     <= {1'b0, tx_hi_reg};
							tx_state_reg  <= TX_START;
							tx_pin_reg    <= 1'b0;
						end else begin
							tx_state_reg  <= TX_IDLE;
							tx_irq_reg    <= 1'b1;
						end
					end else if (tx_step) begin
						tx_cnt_reg <= tx_cnt_reg + 4'h1;
					end
				end
				default: begin
					tx_state_reg <= TX_IDLE;
					tx_pin_reg   <= 1'b1;
				end
			endcase
		end
	end

	// async sample timer: half bit after start edge, then whole bits
	always_ff @(posedge clk_sys_in or negedge rstn) begin
		if (!rstn)
			rx_tmr_reg <= '0;
		else if (rx_state_reg == RX_IDLE)
			rx_tmr_reg <= half;
		else if (rx_tmr_reg == '0)
			rx_tmr_reg <= baud_div_reg - DIV_W'(1);
		else
			rx_tmr_reg <= rx_tmr_reg - DIV_W'(1);
	end

	// receiver shift sequence
	always_ff @(posedge clk_sys_in or negedge rstn) begin
		if (!rstn) begin
			rx_state_reg <= RX_IDLE;
			rx_sh_reg    <= '0;
			rx_cnt_reg   <= 4'h0;
			rx_acc_reg   <= 1'b0;
		end else if (!rx_en) begin
			rx_state_reg <= RX_IDLE;
		end else begin
			case (rx_state_reg)
				RX_IDLE: begin
					rx_cnt_reg <= 4'h0;
					rx_acc_reg <= 1'b0;
					if (sync_on & sel_rise & ~rx_s1_reg)
						rx_state_reg <= RX_DATA;
					else if (~sync_on & rx_fall)
						rx_state_reg <= RX_START;
				end
				RX_START: begin
					if (rx_tick)                                       // false start returns
						rx_state_reg <= rx_s1_reg ? RX_IDLE : RX_DATA;
				end
				RX_DATA: begin
					if (rx_tick) begin
						rx_sh_reg  <= {rx_s1_reg, rx_sh_reg[8:1]};
						rx_acc_reg <= rx_acc_reg ^ rx_s1_reg;
						rx_cnt_reg <= rx_cnt_reg + 4'h1;
						if (rx_cnt_reg == len - 4'h1)
							rx_state_reg <= par_on ? RX_PAR : RX_STOP;
					end
				end
				RX_PAR: begin
					if (rx_tick)
						rx_state_reg <= RX_STOP;
				end
				RX_STOP: begin
					if (rx_tick)
						rx_state_reg <= RX_IDLE;
				end
				default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end

	// frame completion, buffer load and error collection
	always_ff @(posedge clk_sys_in or negedge rstn) begin
		if (!rstn) begin
			rx_first_reg <= 8'h00;
			rx_got1_reg  <= 1'b0;
			pe_pend_reg  <= 1'b0;
			fe_pend_reg  <= 1'b0;
			rxb_reg      <= 16'h0000;
			rx_irq_reg   <= 1'b0;
		end else begin
			rx_irq_reg <= buf_load;
			if (perr_now)
				pe_pend_reg <= 1'b1;
			if (rx_first) begin
				rx_first_reg <= rx_char[7:0];
				rx_got1_reg  <= 1'b1;
				fe_pend_reg  <= fe_pend_reg | ~rx_s1_reg;
			end else if (buf_load) begin
				rxb_reg     <= rx_two_on ? {rx_char[7:0], rx_first_reg} : {7'h00, rx_char};
				rx_got1_reg <= 1'b0;
				pe_pend_reg <= 1'b0;
				fe_pend_reg <= 1'b0;
			end else if (!rx_en) begin
				rx_got1_reg <= 1'b0;
				pe_pend_reg <= 1'b0;
				fe_pend_reg <= 1'b0;
			end
		end
	end

	// sticky status flags; a new event beats a read that clears
	always_ff @(posedge clk_sys_in or negedge rstn) begin
		if (!rstn) begin
			pe_flag_reg   <= 1'b0;
			fe_flag_reg   <= 1'b0;
			ovr_flag_reg  <= 1'b0;
			rx_unread_reg <= 1'b0;
		end else begin
			pe_flag_reg   <= (pe_flag_reg & ~st_read) | (buf_load & (pe_pend_reg | perr_now));
			fe_flag_reg   <= (fe_flag_reg & ~st_read) | (buf_load & (fe_pend_reg | ~rx_s1_reg));
			ovr_flag_reg  <= (ovr_flag_reg & ~st_read) | (buf_load & rx_unread_reg);
			rx_unread_reg <= (rx_unread_reg & ~rx_read) | buf_load;
		end
	end

	// outputs straight from flops
	assign prdata_out              = prdata_reg;
	assign pready_out              = pready_reg;
	assign pslverr_out             = pslverr_reg;
	assign serial_tx_pin_out       = tx_pin_reg;
	assign serial_clock_pin_out    = sclk_pin_reg;
	assign serial_clock_pin_oe_out = sclk_oe_reg;
	assign rx_done_irq_out         = rx_irq_reg;
	assign tx_done_irq_out         = tx_irq_reg;

	// checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn);
	sequence s_tx_last_stop;
		tx_state_reg == TX_STOP && tx_step && tx_cnt_reg == stop_len && !tx_second_reg;
	endsequence
	sequence s_rx_first_frame;
		rx_done && rx_en && rx_two_on && !rx_got1_reg;
	endsequence
	chk_tx_idle_high: assert property (tx_state_reg == TX_IDLE |-> tx_pin_reg)
		else $error("tx line not high while idle");
	chk_tx_start_low: assert property (tx_state_reg == TX_START |-> !tx_pin_reg)
		else $error("start bit not low");
	chk_tx_lsb_first: assert property (tx_state_reg == TX_START && tx_step |=> tx_pin_reg == $past(tx_sh_reg[0]))
		else $error("first data bit is not lsb");
	chk_tx_done_irq: assert property (s_tx_last_stop |=> tx_irq_reg && tx_state_reg == TX_IDLE ##1 !tx_irq_reg)
		else $error("tx done pulse wrong");
	chk_tx_write_starts: assert property (tx_load |=> tx_pend_reg ##0 status[ST_TX_ACT])
		else $error("write did not start transmit");
	chk_rx_two_frame: assert property (s_rx_first_frame |=> !rx_irq_reg && rx_got1_reg)
		else $error("rx irq after first of two frames");
	chk_rx_irq_load: assert property (buf_load |=> rx_irq_reg && rx_unread_reg ##1 !rx_irq_reg)
		else $error("rx irq not tied to buffer load");
	chk_rx_msb_zero: assert property (rx_irq_reg && !$past(rx_two_on) && !$past(ext) |-> rxb_reg[15:8] == 8'h00)
		else $error("rx buffer msb not zero");
	chk_overrun_set: assert property (buf_load && rx_unread_reg |=> ovr_flag_reg)
		else $error("overrun not flagged");
	chk_framing_set: assert property (buf_load && !rx_two_on && !rx_s1_reg |=> fe_flag_reg)
		else $error("framing error not flagged");
	chk_clk_pin_dir: assert property (##1 sclk_oe_reg == $past(sync_on && mode_a_reg.clk_src))
		else $error("clock pin direction wrong");
endmodule // dmsp_top
`default_nettype wire

/* sim/dmsp_node.sv */
`timescale 1ns/1ns
`default_nettype none
// remote async node: drives our rx line, decodes our tx line
module dmsp_node #(
	parameter int BIT = 16                 // bit period, clk cycles
) (
	input  wire logic clk_in,
	input  wire logic tx_line_in,
	output logic      rx_line_out
);
	initial rx_line_out = 1'b1;        // idle high line
	// send n bits of a ready-made frame, first bit first
	task automatic send(input logic [15:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk_in) rx_line_out <= f[i];
			repeat (BIT - 1) @(posedge clk_in);
		end
		@(posedge clk_in) rx_line_out <= 1'b1;
	endtask
	// wait for a start bit, then sample each bit mid-cell
	task automatic recv(output logic [15:0] f, input int n);
		f = '0;
		while (tx_line_in !== 1'b0) @(posedge clk_in);
		repeat (BIT / 2) @(posedge clk_in);
		for (int i = 0; i < n; i++) begin
			f[i] = tx_line_in;
			repeat (BIT) @(posedge clk_in);
		end
	endtask
endmodule // dmsp_node
`default_nettype wire

/* sim/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import dmsp_pkg::*;
	logic        clk_sys = 1'b0, rstn = 1'b0;  // clock and reset
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic        pready, pslverr, err, rx_pin, tx_pin, ck_o, ck_oe, rx_irq, tx_irq;
	logic [15:0] f;                            // decoded tx frame
	int          num_errors = 0, cmp_count = 0, rx_cnt = 0, tx_cnt = 0;
	dmsp_top #(.DIV_DEFAULT(16)) uut (.clk_sys_in(clk_sys), .rstn_in(rstn),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .serial_rx_pin_in(rx_pin), .serial_tx_pin_out(tx_pin),
		.serial_clock_pin_in(1'b1), .serial_clock_pin_out(ck_o),
		.serial_clock_pin_oe_out(ck_oe), .rx_done_irq_out(rx_irq),
		.tx_done_irq_out(tx_irq));
	dmsp_node #(.BIT(16)) node (.clk_in(clk_sys), .tx_line_in(tx_pin),
		.rx_line_out(rx_pin));
	initial forever #10 clk_sys = ~clk_sys;    // 50 mhz
	// count completion pulses
	always @(posedge clk_sys) begin
		if (rx_irq === 1'b1) rx_cnt++;
		if (tx_irq === 1'b1) tx_cnt++;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer: setup, then access until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge clk_sys) penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	// one 8-bit frame into the receiver, then settle
	task automatic rxf(input logic [10:0] fr, input int n);
		node.send({5'h00, fr}, n);
		repeat (20) @(posedge clk_sys);
	endtask
	task automatic stop_test;
		$display("errors %0d, comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		stop_test;
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		apb(0, ADDR_MODE_A, 0); check(q, 32'h0000_0081);
		apb(0, ADDR_MODE_B, 0); check(q, 32'h0000_0000);
		apb(0, 8'h20, 0); check({31'h0, err}, 32'h1);
		apb(1, ADDR_MODE_A, 32'h0000_00C9);                 // idle change
		fork // 8n1 transmit, lsb first
			node.recv(f, 10);
			begin apb(1, ADDR_TXS_L, 32'h0000_00A5); apb(0, ADDR_STATUS, 0); end
		join
		check(q[ST_TX_ACT], 1'b1);
		check(f, {6'h00, 1'b1, 8'hA5, 1'b0});
		repeat (40) @(posedge clk_sys);
		check(tx_cnt, 1);
		apb(1, ADDR_MODE_A, 32'h0000_00F5);                 // 7 bits, even, 2 stops
		fork
			node.recv(f, 11);
			apb(1, ADDR_TXS_L, 32'h0000_0055);
		join
		check(f, {5'h00, 2'b11, 1'b0, 7'h55, 1'b0});
		apb(1, ADDR_MODE_A, 32'h0000_00C9);
		rxf({1'b1, 8'h3C, 1'b0}, 10);
		check(rx_cnt, 1);
		apb(0, ADDR_RXB_W, 0); check(q, 32'h0000_003C);
		rxf({1'b0, 8'h11, 1'b0}, 10);                       // low stop bit
		apb(0, ADDR_RXB_L, 0); check(q, 32'h0000_0011);
		apb(0, ADDR_STATUS, 0); check(q[2:0], 3'b010);
		rxf({1'b1, 8'h01, 1'b0}, 10);
		rxf({1'b1, 8'h02, 1'b0}, 10);                       // previous unread
		apb(0, ADDR_STATUS, 0); check(q[2:0], 3'b001);
		apb(0, ADDR_RXB_W, 0);
		apb(1, ADDR_MODE_A, 32'h0000_00E9);                 // odd parity
		rxf({1'b1, 1'b0, 8'h03, 1'b0}, 11);                 // wrong parity bit
		apb(0, ADDR_STATUS, 0); check(q[2:0], 3'b100);
		apb(0, ADDR_RXB_W, 0);
		apb(1, ADDR_MODE_A, 32'h0000_00C9);
		apb(1, ADDR_MODE_B, 32'h0000_0002);                 // two-frame receive
		rx_cnt = 0;
		rxf({1'b1, 8'h12, 1'b0}, 10);
		check(rx_cnt, 0);
		rxf({1'b1, 8'h34, 1'b0}, 10);
		check(rx_cnt, 1);
		apb(0, ADDR_RXB_W, 0); check(q, 32'h0000_3412);
		apb(1, ADDR_MODE_B, 32'h0000_0004);                 // two-frame transmit
		check(ck_oe, 1'b0);
		fork // first frame of a pair carries the low byte
			node.recv(f, 10);
			apb(1, ADDR_TXS_W, 32'h0000_5AA5);
		join
		check(f, {6'h00, 1'b1, 8'hA5, 1'b0});
		check(tx_cnt, 2);
		repeat (200) @(posedge clk_sys);
		check(tx_cnt, 3);
		apb(1, ADDR_MODE_B, 32'h0000_0008);                 // clocked mode, internal clock
		repeat (4) @(posedge clk_sys);
		check(ck_oe, 1'b1);
		stop_test;
	end
endmodule // testbench
`default_nettype wire
